// File: include/nms_mgmt_if.sv
`timescale 1ns/1ps
interface nms_mgmt_if;
  logic mdc;
  logic host_mdio_o;
  logic host_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio;

  // Shared data line with a pull-up when nobody drives
  assign mdio = host_mdio_oe ? host_mdio_o :
                dev_mdio_oe  ? dev_mdio_o  : 1'b1;

  modport host (output mdc, output host_mdio_o, output host_mdio_oe,
                input mdio);
  modport dev  (input mdc, output dev_mdio_o, output dev_mdio_oe,
                input mdio);
endinterface

// File: include/nms_pkg.sv
package nms_pkg;
  typedef logic [3:0]  nms_addr_t;
  typedef logic [15:0] nms_word_t;
  typedef logic [3:0]  nms_code_t;
  typedef logic [4:0]  nms_phy_t;
  typedef logic [3:0]  nms_res_t;

  // Device register and fields
  localparam logic [4:0] REG_NEG_STATUS = 5'h11;
  localparam int         RES_FAST_FULL  = 15;
  localparam int         RES_FAST_HALF  = 14;
  localparam int         RES_SLOW_FULL  = 13;
  localparam int         RES_SLOW_HALF  = 12;
  localparam int         ADDR_LSB       = 4;
  localparam int         ADDR_MSB       = 8;
  localparam nms_phy_t   ADDR_RESET     = 5'h01;
  localparam nms_code_t  MON_RESET      = 4'h0;
  localparam nms_res_t   RES_RESET      = 4'h0;

  // Monitor codes
  localparam nms_code_t MON_IDLE      = 4'h0;
  localparam nms_code_t MON_ABIL_OK   = 4'h1;
  localparam nms_code_t MON_ACK_OK    = 4'h2;
  localparam nms_code_t MON_ACK_FAIL  = 4'h3;
  localparam nms_code_t MON_CONS_OK   = 4'h4;
  localparam nms_code_t MON_CONS_FAIL = 4'h5;
  localparam nms_code_t MON_PD_READY  = 4'h6;
  localparam nms_code_t MON_PD_FAIL   = 4'h7;
  localparam nms_code_t MON_DONE      = 4'h8;

  // Management frame
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam int         PRE_BITS   = 32;
  localparam int         HDR_LAST   = 12;
  localparam int         TA_BIT     = 46;
  localparam int         DATA_BIT   = 48;
  localparam int         FRAME_BITS = 64;
  localparam int         RD_DRV_TA  = 1;
  localparam int         RD_END     = 18;
  localparam int         WR_LAST    = 17;

  // Clock of the management bus
  localparam int CLK_NS       = 50;
  localparam int MDC_PERIOD_NS = 800;
  localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * CLK_NS);

  // Controller registers
  localparam nms_addr_t CR_CMD   = 4'h0;
  localparam nms_addr_t CR_WDATA = 4'h1;
  localparam nms_addr_t CR_RDATA = 4'h2;
  localparam nms_addr_t CR_ISTAT = 4'h3;
  localparam nms_addr_t CR_IMASK = 4'h4;
  localparam int CMD_GO    = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_PHY_L = 2;
  localparam int CMD_REG_L = 7;
  localparam int IRQ_DONE  = 0;
endpackage

// File: rtl/nms_mgr_end.sv
`timescale 1ns/1ps
module nms_mgr_end (
  input  wire logic               i_mclk,  // System clock
  input  wire logic               i_rst,   // Async reset, high
  nms_mgmt_if.host                mgmt,    // Management bus
  input  wire nms_pkg::nms_addr_t i_addr,  // Register address
  input  wire nms_pkg::nms_word_t i_wdata, // Write data
  input  wire logic               i_wr,    // Write strobe
  input  wire logic               i_rd,    // Read strobe
  output nms_pkg::nms_word_t      o_rdata, // Read data, next cycle
  output logic                    o_irq    // Interrupt, level
);
  import nms_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Clock divider and data input synchroniser

  logic [3:0] div_ff;
  logic       mdc_ff, tick, fall_ev, smp_ev;
  logic       s1_ff, s2_ff, s3_ff, din_ff;

  assign tick    = (div_ff == 4'(MDC_HALF_CYC - 1));
  assign fall_ev = tick && mdc_ff;
  // Sample one cycle after mdc rises: a device answer needs the round trip
  // through both synchronisers before it settles here
  assign smp_ev  = mdc_ff && (div_ff == 4'h0);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 4'h0;
      mdc_ff <= 1'b0;
    end else begin
      div_ff <= tick ? 4'h0 : div_ff + 4'h1;
      if (tick) begin
        mdc_ff <= !mdc_ff;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff  <= 1'b1;
      s2_ff  <= 1'b1;
      s3_ff  <= 1'b1;
      din_ff <= 1'b1;
    end else begin
      s1_ff <= mgmt.mdio;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        din_ff <= s3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame engine

  logic       busy_ff, wop_ff, done;
  logic [63:0] frame_ff;
  logic [6:0] bit_ff;
  nms_word_t  cap_ff, wd_ff, rd_ff, nxt_cap;
  logic       mo_ff, moe_ff, go;
  logic [1:0] op;

  // Caller picks the station address per device
  assign go = i_wr && (i_addr == CR_CMD) && i_wdata[CMD_GO] &&
              !busy_ff;
  assign op = i_wdata[CMD_WRITE] ? OP_WRITE : OP_READ;
  assign done = busy_ff && smp_ev && (bit_ff == 7'(FRAME_BITS));
  assign nxt_cap = {cap_ff[14:0], din_ff};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      busy_ff  <= 1'b0;
      wop_ff   <= 1'b0;
      frame_ff <= 64'h0;
      bit_ff   <= 7'h00;
      cap_ff   <= 16'h0000;
      rd_ff    <= 16'h0000;
      mo_ff    <= 1'b1;
      moe_ff   <= 1'b0;
    end else begin
      if (go) begin
        busy_ff  <= 1'b1;
        wop_ff   <= i_wdata[CMD_WRITE];
        bit_ff   <= 7'h00;
        // Address fields go out MSB first
        frame_ff <= {32'hFFFFFFFF, 2'h1, op,
                     i_wdata[CMD_PHY_L +: 5], i_wdata[CMD_REG_L +: 5],
                     2'h2, wd_ff};
      end else if (busy_ff && fall_ev &&
                   bit_ff < 7'(FRAME_BITS)) begin
        mo_ff    <= frame_ff[63];
        moe_ff   <= wop_ff || (bit_ff < 7'(TA_BIT));
        frame_ff <= {frame_ff[62:0], 1'b0};
        bit_ff   <= bit_ff + 7'h01;
      end else if (busy_ff && smp_ev && bit_ff != 7'h00) begin
        if (!wop_ff && bit_ff > 7'(DATA_BIT)) begin
          cap_ff <= nxt_cap;
        end
        if (done) begin
          busy_ff <= 1'b0;
          moe_ff  <= 1'b0;
          mo_ff   <= 1'b1;
          if (!wop_ff) begin
            rd_ff <= nxt_cap;
          end
        end
      end
    end
  end

  assign mgmt.mdc          = mdc_ff;
  assign mgmt.host_mdio_o  = mo_ff;
  assign mgmt.host_mdio_oe = moe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Software registers

  logic ist_ff, imask_ff;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wd_ff    <= 16'h0000;
      imask_ff <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == CR_WDATA) begin
        wd_ff <= i_wdata;
      end
      if (i_addr == CR_IMASK) begin
        imask_ff <= i_wdata[IRQ_DONE];
      end
    end
  end

  // A completion in the clearing cycle keeps the flag set
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ist_ff <= 1'b0;
    end else begin
      ist_ff <= (ist_ff && !(i_wr && i_addr == CR_ISTAT &&
                 i_wdata[IRQ_DONE])) || done;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ist_ff && imask_ff;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        CR_CMD:   o_rdata <= {15'h0000, busy_ff};
        CR_WDATA: o_rdata <= wd_ff;
        CR_RDATA: o_rdata <= rd_ff;
        CR_ISTAT: o_rdata <= {15'h0000, ist_ff};
        CR_IMASK: o_rdata <= {15'h0000, imask_ff};
        default:  o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end
endmodule

// File: rtl/nms_phy_end.sv
`timescale 1ns/1ps
module nms_phy_end (
  input  wire logic           i_mclk,         // System clock
  input  wire logic           i_rst,          // Async reset, high
  nms_mgmt_if.dev             mgmt,           // Management bus
  input  wire logic           i_an_active,    // Auto-negotiation mode
  input  wire logic           i_an_done,      // Negotiation success pulse
  input  wire logic           i_res_fast,     // Result is 100 Mbps
  input  wire logic           i_res_full,     // Result is full duplex
  input  wire nms_pkg::nms_code_t i_an_state, // Arbitration state code
  output logic [4:0]          o_station_addr, // Current station address
  output nms_pkg::nms_word_t  o_status_word,  // Register image
  output logic                o_wr_strobe     // Register was written
);
  import nms_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR  = 4'b0010,
    ST_RD   = 4'b0100,
    ST_WR   = 4'b1000
  } nms_dev_st_t;

  function automatic nms_res_t res_onehot(input logic fast,
                                          input logic full);
    nms_res_t r;
    r = 4'h0;
    case ({fast, full})
      2'b11:   r[RES_FAST_FULL - 12] = 1'b1;
      2'b10:   r[RES_FAST_HALF - 12] = 1'b1;
      2'b01:   r[RES_SLOW_FULL - 12] = 1'b1;
      default: r[RES_SLOW_HALF - 12] = 1'b1;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic mdc_s1_ff, mdc_s2_ff, mdc_s3_ff, mdc_st_ff;
  logic dat_s1_ff, dat_s2_ff, dat_s3_ff, dat_st_ff;
  logic mdc_rise, mdc_fall;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mdc_s1_ff <= 1'b0;
      mdc_s2_ff <= 1'b0;
      mdc_s3_ff <= 1'b0;
      mdc_st_ff <= 1'b0;
    end else begin
      mdc_s1_ff <= mgmt.mdc;
      mdc_s2_ff <= mdc_s1_ff;
      mdc_s3_ff <= mdc_s2_ff;
      if (mdc_s2_ff == mdc_s3_ff) begin
        mdc_st_ff <= mdc_s3_ff;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dat_s1_ff <= 1'b1;
      dat_s2_ff <= 1'b1;
      dat_s3_ff <= 1'b1;
      dat_st_ff <= 1'b1;
    end else begin
      dat_s1_ff <= mgmt.mdio;
      dat_s2_ff <= dat_s1_ff;
      dat_s3_ff <= dat_s2_ff;
      if (dat_s2_ff == dat_s3_ff) begin
        dat_st_ff <= dat_s3_ff;
      end
    end
  end

  assign mdc_rise = (mdc_s2_ff == mdc_s3_ff) && mdc_s3_ff && !mdc_st_ff;
  assign mdc_fall = (mdc_s2_ff == mdc_s3_ff) && !mdc_s3_ff && mdc_st_ff;

  ////////////////////////////////////////////////////////////////////////
  // Frame receiver

  nms_dev_st_t st_ff;
  logic [5:0]  ones_ff;
  logic [4:0]  cnt_ff;
  logic [11:0] hdr_ff;
  nms_word_t   sh_ff;
  logic        mdio_o_ff, mdio_oe_ff;
  logic [12:0] hdr_all;
  logic        hit;
  logic        wr_hit;
  nms_word_t   wr_word;

  assign hdr_all = {hdr_ff, dat_st_ff};
  // Address arrives MSB first, so a left shift leaves it in order
  assign hit = hdr_all[12] &&
               (hdr_all[9:5] == o_station_addr) &&
               (hdr_all[4:0] == REG_NEG_STATUS);
  assign wr_hit = (st_ff == ST_WR) && mdc_rise &&
                  (cnt_ff == 5'(WR_LAST));
  assign wr_word = {sh_ff[14:0], dat_st_ff};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_ff      <= ST_IDLE;
      ones_ff    <= 6'h00;
      cnt_ff     <= 5'h00;
      hdr_ff     <= 12'h000;
      sh_ff      <= 16'h0000;
      mdio_o_ff  <= 1'b1;
      mdio_oe_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (mdc_rise) begin
            if (dat_st_ff) begin
              if (ones_ff != 6'(PRE_BITS)) begin
                ones_ff <= ones_ff + 6'h01;
              end
            end else begin
              if (ones_ff == 6'(PRE_BITS)) begin
                st_ff  <= ST_HDR;
                cnt_ff <= 5'h00;
              end
              ones_ff <= 6'h00;
            end
          end
        end
        ST_HDR: begin
          if (mdc_rise) begin
            hdr_ff <= hdr_all[11:0];
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == 5'(HDR_LAST)) begin
              cnt_ff <= 5'h00;
              if (hit && hdr_all[11:10] == OP_READ) begin
                st_ff <= ST_RD;
                sh_ff <= o_status_word;
              end else if (hit && hdr_all[11:10] == OP_WRITE) begin
                st_ff <= ST_WR;
              end else begin
                st_ff <= ST_IDLE;
              end
            end
          end
        end
        ST_RD: begin
          if (mdc_fall) begin
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == 5'(RD_DRV_TA)) begin
              mdio_oe_ff <= 1'b1;
              mdio_o_ff  <= 1'b0;
            end else if (cnt_ff > 5'(RD_DRV_TA) &&
                         cnt_ff < 5'(RD_END)) begin
              mdio_o_ff <= sh_ff[15];
              sh_ff     <= {sh_ff[14:0], 1'b0};
            end
          end
          // Release after the last bit has been sampled
          if (mdc_rise && cnt_ff == 5'(RD_END)) begin
            mdio_oe_ff <= 1'b0;
            mdio_o_ff  <= 1'b1;
            st_ff      <= ST_IDLE;
          end
        end
        ST_WR: begin
          if (mdc_rise) begin
            cnt_ff <= cnt_ff + 5'h01;
            sh_ff  <= wr_word;
            if (cnt_ff == 5'(WR_LAST)) begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          st_ff      <= ST_IDLE;
          mdio_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign mgmt.dev_mdio_o  = mdio_o_ff;
  assign mgmt.dev_mdio_oe = mdio_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Register fields

  nms_res_t  res_ff;
  nms_code_t mon_ff;

  // Only the address field takes written data; other bits are dropped
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_station_addr <= ADDR_RESET;
      o_wr_strobe    <= 1'b0;
    end else begin
      o_wr_strobe <= wr_hit;
      if (wr_hit) begin
        o_station_addr <= wr_word[ADDR_MSB:ADDR_LSB];
      end
    end
  end

  // Result bits cleared outside auto-negotiation
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      res_ff <= RES_RESET;
    end else if (!i_an_active) begin
      res_ff <= RES_RESET;
    end else if (i_an_done) begin
      res_ff <= res_onehot(i_res_fast,
                           i_res_full);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mon_ff <= MON_RESET;
    end else if (i_an_state <= MON_DONE) begin
      mon_ff <= i_an_state;
    end else begin
      mon_ff <= MON_IDLE;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_status_word <= 16'h0000;
    end else begin
      o_status_word <= {res_ff, 3'h0, o_station_addr, mon_ff};
    end
  end
endmodule

// File: verif/nms_negstat_sva.sv
`timescale 1ns/1ps
module nms_negstat_sva (
  input wire logic               i_mclk,         // System clock
  input wire logic               i_rst,          // Async reset, high
  input wire logic               mdc,            // Management clock
  input wire logic               host_mdio_oe,   // Manager drives line
  input wire logic               dev_mdio_oe,    // Device drives line
  input wire logic               i_an_active,    // Negotiation mode
  input wire logic               i_an_done,      // Negotiation success
  input wire logic               i_res_fast,     // Result 100 Mbps
  input wire logic               i_res_full,     // Result full duplex
  input wire nms_pkg::nms_code_t i_an_state,     // Arbitration code
  input wire logic [4:0]         o_station_addr, // Address field
  input wire nms_pkg::nms_word_t o_status_word,  // Register image
  input wire logic               o_wr_strobe     // Register written
);
  import nms_pkg::*;
  logic [1:0] age_ff;
  logic       done_ok;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Edges since reset release, saturating
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      age_ff <= 2'h0;
    end else if (age_ff != 2'h3) begin
      age_ff <= age_ff + 2'h1;
    end
  end
  assign done_ok = i_an_done && i_an_active;

  ////////////////////////////////////////////////////////////////////////////
  fast_full_a: assert property (
    done_ok && i_res_fast && i_res_full |-> ##2 o_status_word[RES_FAST_FULL])
    else $error("fast full result bit missing");
  fast_half_a: assert property (
    done_ok && i_res_fast && !i_res_full |-> ##2 o_status_word[RES_FAST_HALF])
    else $error("fast half result bit missing");
  slow_full_a: assert property (
    done_ok && !i_res_fast && i_res_full |-> ##2 o_status_word[RES_SLOW_FULL])
    else $error("slow full result bit missing");
  slow_half_a: assert property (
    done_ok && !i_res_fast && !i_res_full |-> ##2 o_status_word[RES_SLOW_HALF])
    else $error("slow half result bit missing");
  one_result_a: assert property (
    done_ok |-> ##2 $onehot(o_status_word[15:12]))
    else $error("result bits not one-hot");
  idle_result_a: assert property (
    !i_an_active |-> ##2 o_status_word[15:12] == 4'h0)
    else $error("result bits set outside negotiation");
  rsv_zero_a: assert property (o_status_word[11:9] == 3'h0)
    else $error("reserved bits not zero");
  addr_image_a: assert property (
    age_ff != 2'h0 |-> o_status_word[8:4] == $past(o_station_addr))
    else $error("address field image wrong");
  addr_write_a: assert property ($changed(o_station_addr) |-> o_wr_strobe)
    else $error("address changed without write");
  line_clash_a: assert property (!(host_mdio_oe && dev_mdio_oe))
    else $error("both ends drive data line");
  dev_drive_a: assert property ($rose(dev_mdio_oe) |-> !mdc)
    else $error("device drive started with clock high");
  mon_follow_a: assert property (
    age_ff == 2'h3 |-> o_status_word[3:0] ==
      (($past(i_an_state, 2) > 4'h8) ? 4'h0 : $past(i_an_state, 2)))
    else $error("monitor code does not follow state");

  cover property (o_status_word[RES_FAST_FULL]);
  cover property (o_wr_strobe);
  cover property (o_status_word[3:0] == MON_DONE);
endmodule

// File: verif/phy_negotiation_status_register_tb_top.sv
`timescale 1ns/1ps
module phy_negotiation_status_register_tb_top;
  import nms_pkg::*;
  logic        i_mclk, i_rst, i_an_active, i_an_done, i_res_fast, i_res_full;
  logic        i_wr, i_rd, o_irq, o_wr_strobe, mask_on;
  nms_code_t   i_an_state;
  nms_addr_t   i_addr;
  nms_word_t   i_wdata, o_rdata, o_status_word, q, d;
  logic [4:0]  o_station_addr;
  nms_phy_t    cur_addr;
  logic [63:0] wire_sr, exp_frame;
  logic [1:0]  rc;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  nms_mgmt_if mgmt ();
  nms_phy_end i_nms_phy_end (.i_mclk(i_mclk), .i_rst(i_rst), .mgmt(mgmt),
    .i_an_active(i_an_active), .i_an_done(i_an_done),
    .i_res_fast(i_res_fast), .i_res_full(i_res_full),
    .i_an_state(i_an_state), .o_station_addr(o_station_addr),
    .o_status_word(o_status_word), .o_wr_strobe(o_wr_strobe));
  nms_mgr_end i_nms_mgr_end (.i_mclk(i_mclk), .i_rst(i_rst), .mgmt(mgmt),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq));
  nms_negstat_sva i_nms_negstat_sva (.i_mclk(i_mclk), .i_rst(i_rst),
    .mdc(mgmt.mdc), .host_mdio_oe(mgmt.host_mdio_oe),
    .dev_mdio_oe(mgmt.dev_mdio_oe), .i_an_active(i_an_active),
    .i_an_done(i_an_done), .i_res_fast(i_res_fast), .i_res_full(i_res_full),
    .i_an_state(i_an_state), .o_station_addr(o_station_addr),
    .o_status_word(o_status_word), .o_wr_strobe(o_wr_strobe));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // Bits the manager puts on the line, as the device sees them
  always @(posedge mgmt.mdc) begin
    if (mgmt.host_mdio_oe) wire_sr <= {wire_sr[62:0], mgmt.mdio};
  end

  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input nms_word_t got, input nms_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic nms_word_t exp_word(input nms_res_t r,
                                         input nms_phy_t a,
                                         input nms_code_t m);
    return {r, 3'h0, a, m};
  endfunction

  task automatic wr(input nms_addr_t a, input nms_word_t v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input nms_addr_t a, output nms_word_t v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    v = o_rdata;
  endtask

  // One management frame to the status register, then interrupt handling
  task automatic mframe(input logic w, input nms_phy_t p, input nms_word_t v,
                        output nms_word_t r);
    int n;
    n = 0;
    wr(CR_WDATA, v);
    wr(CR_CMD, {4'h0, REG_NEG_STATUS, p, w, 1'b1});
    r = 16'h0001;
    while (r[0] !== 1'b0 && n < 2000) begin
      rd(CR_CMD, r);
      n++;
    end
    chk(r, 16'h0000);
    chk({15'h0, o_irq}, {15'h0, mask_on});
    wr(CR_ISTAT, 16'h0001);
    repeat (2) @(negedge i_mclk);
    chk({15'h0, o_irq}, 16'h0);
    rd(CR_RDATA, r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    i_an_active = 1'b0;
    i_an_done = 1'b0;
    i_res_fast = 1'b0;
    i_res_full = 1'b0;
    i_an_state = MON_IDLE;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = CR_CMD;
    i_wdata = 16'h0;
    mask_on = 1'b0;
    d = 16'($urandom(32'hC284));
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    cur_addr = ADDR_RESET;
    wr(CR_IMASK, 16'h0001);
    mask_on = 1'b1;
    rd(4'hF, q);
    chk(q, 16'h0);
    mframe(1'b0, cur_addr, 16'h0, q);
    chk(q, exp_word(RES_RESET, cur_addr, MON_RESET));
    // New station address, every other bit random
    d = 16'($urandom());
    d[8:4] = d[8:4] | 5'h02;
    mframe(1'b1, cur_addr, d, q);
    exp_frame = {32'hFFFFFFFF, 4'h5, cur_addr, REG_NEG_STATUS, 2'h2, d};
    for (int j = 0; j < 4; j++) begin
      chk(wire_sr[j*16 +: 16], exp_frame[j*16 +: 16]);
    end
    cur_addr = d[8:4];
    chk({11'h0, o_station_addr}, {11'h0, cur_addr});
    mframe(1'b0, ~cur_addr, 16'h0, q);
    chk(q, 16'hFFFF);
    mframe(1'b0, cur_addr, 16'h0, q);
    chk(q, exp_word(4'h0, cur_addr, MON_IDLE));
    i_an_active <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      rc = (k < 4) ? 2'(k) : 2'($urandom());
      @(posedge i_mclk);
      i_res_fast <= rc[1];
      i_res_full <= rc[0];
      i_an_state <= 4'(k);
      i_an_done <= 1'b1;
      @(posedge i_mclk);
      i_an_done <= 1'b0;
      mframe(1'b0, cur_addr, 16'($urandom()), q);
      chk(q, exp_word(4'h1 << rc, cur_addr,
                      4'(k)));
    end
    wr(CR_IMASK, 16'h0);
    mask_on = 1'b0;
    i_an_active <= 1'b0;
    mframe(1'b0, cur_addr, 16'h0, q);
    chk(q, exp_word(4'h0, cur_addr, MON_DONE));
    chk({15'h0, mgmt.mdio}, 16'h0001);
    print_verdict();
  end
endmodule
